/* File: core/ppc_pin_cell.sv */
// Programmable pin cell: delay line, six storage elements, AXI4-Lite regs
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_cell
    import ppc_pkg::*;
#(
    parameter bit HAS_OUTPUT = 1'b1
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pad side
    input wire logic pad_in,
    output logic pad_out,
    output logic pad_oe,
    // Fabric data and control
    input wire logic out_data_upper,
    input wire logic out_data_lower,
    input wire logic tri_ctrl_upper,
    input wire logic tri_ctrl_lower,
    input wire logic out_tri_upper_clock,
    input wire logic out_tri_lower_clock,
    input wire logic in_upper_clock,
    input wire logic in_lower_clock,
    input wire logic out_pair_gate,
    input wire logic tristate_pair_gate,
    input wire logic in_pair_gate,
    input wire logic set_reset_line,
    input wire logic opposite_force_line,
    input wire logic global_force_line,
    // Fabric results
    output logic in_plain,
    output logic in_reg_upper,
    output logic in_reg_lower
);
    // Register state
    logic [PPC_CTRL_W-1:0] ctrl;
    logic [31:0] elem;
    logic [PPC_NINV-1:0] inv;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;

    // Write decode: address and data taken together
    wire wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    wire wr_ctrl = wr_go && s_axi_awaddr == PPC_OFS_CTRL;
    wire wr_elem = wr_go && s_axi_awaddr == PPC_OFS_ELEM;
    wire wr_inv = wr_go && s_axi_awaddr == PPC_OFS_INV;
    wire wr_hit = wr_ctrl || wr_elem || wr_inv;
    wire [31:0] wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
        {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire locked = ctrl[PPC_C_LOCK];
    // Delay bits become read-only once the cell is locked
    wire [14:0] ctrl_wmask = wmask[14:0] &
        (locked ? ~PPC_DELAY_MASK : 15'h7FFF);
    wire [14:0] next_ctrl_raw = (ctrl & ~ctrl_wmask) |
        (s_axi_wdata[14:0] & ctrl_wmask);
    // Lock is sticky until reset
    wire [14:0] next_ctrl = next_ctrl_raw | {14'h0000, locked};
    wire [31:0] next_elem = (elem & ~wmask) | (s_axi_wdata & wmask);
    wire [12:0] next_inv = (inv & ~wmask[12:0]) |
        (s_axi_wdata[12:0] & wmask[12:0]);
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !s_axi_rvalid;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    // Register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= PPC_CTRL_RST;
            elem <= PPC_ELEM_RST;
            inv <= PPC_INV_RST;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= PPC_RESP_OK;
        end else begin
            if (wr_ctrl) ctrl <= next_ctrl;
            if (wr_elem) elem <= next_elem;
            if (wr_inv) inv <= next_inv;
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? PPC_RESP_OK : PPC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Fabric inputs with their polarity inverters
    wire [PPC_NINV-1:0] fab_raw = {opposite_force_line, set_reset_line,
        in_pair_gate, tristate_pair_gate, out_pair_gate, in_lower_clock,
        in_upper_clock, out_tri_lower_clock, out_tri_upper_clock,
        tri_ctrl_lower, tri_ctrl_upper, out_data_lower, out_data_upper};
    wire [PPC_NINV-1:0] fab = fab_raw ^ inv;
    wire f_o1 = fab[0];
    wire f_o2 = fab[1];
    wire f_t1 = fab[2];
    wire f_t2 = fab[3];
    wire f_otck1 = fab[4];
    wire f_otck2 = fab[5];
    wire f_ick1 = fab[6];
    wire f_ick2 = fab[7];
    // Unused enables read as asserted
    wire f_oce = fab[8] || !ctrl[PPC_C_OUT_GATE];
    wire f_tce = fab[9] || !ctrl[PPC_C_TRI_GATE];
    wire f_ice = fab[10] || !ctrl[PPC_C_IN_GATE];
    wire f_sr = fab[11];
    wire f_rev = fab[12];

    // Input delay line; sub-cycle taps round up to whole cycles
    localparam int LINE_LEN = PPC_NTAP * PPC_TAP_CYC;
    logic [PPC_COARSE_CYC-1:0] coarse_sh;
    logic [LINE_LEN-1:0] line_sh;
    // Coarse stage feeds both routes, so one enable serves both
    wire stage0 = ctrl[PPC_C_COARSE] ?
        coarse_sh[PPC_COARSE_CYC-1] : pad_in;
    wire [PPC_NTAP-1:0] tap;
    assign tap[0] = stage0;
    genvar k;
    generate
        for (k = 1; k < PPC_NTAP; k++) begin : g_tap
            assign tap[k] = line_sh[k*PPC_TAP_CYC-1];
        end
    endgenerate
    wire [2:0] atap = ctrl[PPC_C_ATAP+2:PPC_C_ATAP];
    wire [1:0] stap = ctrl[PPC_C_STAP+1:PPC_C_STAP];
    // Any of eight taps to the plain path, every second to storage
    assign in_plain = tap[atap];
    wire sync_d = tap[{stap, 1'b0}];

    // Delay line shift; pad level is not reset-dependent
    always_ff @(posedge aclk) begin
        // Oldest sample falls off the end on purpose
        coarse_sh <= PPC_COARSE_CYC'({coarse_sh, pad_in});
        line_sh <= LINE_LEN'({line_sh, stage0});
    end

    // Per-element data, clock level and enable
    wire ddr_out = ctrl[PPC_C_DDR_OUT];
    wire ddr_tri = ctrl[PPC_C_DDR_TRI];
    wire [PPC_NEL-1:0] el_d = {f_t2, f_t1, f_o2, f_o1, sync_d, sync_d};
    // Shared out/tri clocks; lower input uses inverse in double-rate
    wire in_l_ck = ctrl[PPC_C_DDR_IN] ? !f_ick1 : f_ick2;
    wire [PPC_NEL-1:0] el_ck = {f_otck2, f_otck1, f_otck2, f_otck1,
        in_l_ck, f_ick1};
    wire [PPC_NEL-1:0] el_ce = {f_tce, f_tce, f_oce, f_oce,
        f_ice, f_ice};
    wire [5:0] cfg_latch = elem[PPC_E_LATCH+5:PPC_E_LATCH];
    wire [5:0] cfg_async = elem[PPC_E_ASYNC+5:PPC_E_ASYNC];
    wire [5:0] cfg_fone = elem[PPC_E_FONE+5:PPC_E_FONE];
    wire [5:0] cfg_init = elem[PPC_E_INIT+5:PPC_E_INIT];
    // Upper element's force level governs a double-rate out or tri pair
    wire [5:0] fone_eff = {ddr_tri ? cfg_fone[4] : cfg_fone[5],
        cfg_fone[4], ddr_out ? cfg_fone[2] : cfg_fone[3],
        cfg_fone[2:0]};
    // A zero start value on either half zeroes a double-rate out or tri pair
    wire o_init = cfg_init[2] && cfg_init[3];
    wire t_init = cfg_init[4] && cfg_init[5];
    wire [5:0] init_eff = {ddr_tri ? t_init : cfg_init[5],
        ddr_tri ? t_init : cfg_init[4],
        ddr_out ? o_init : cfg_init[3],
        ddr_out ? o_init : cfg_init[2], cfg_init[1:0]};
    // Both force lines drive every element
    wire force_any = f_sr || f_rev;
    wire [5:0] force_val = (f_sr && f_rev) ? 6'h00 :
        (f_sr ? fone_eff : ~fone_eff);

    logic [PPC_NEL-1:0] ck_q;
    logic [PPC_NEL-1:0] q;
    logic [PPC_NEL-1:0] next_q;
    genvar i;
    generate
        for (i = 0; i < PPC_NEL; i++) begin : g_el
            wire present = HAS_OUTPUT || i < 2;
            wire ck_rise = el_ck[i] && !ck_q[i];
            // Latch gate is the clock level; flop uses the rising edge
            wire event_now = cfg_latch[i] ? el_ck[i] : ck_rise;
            always_comb begin
                next_q[i] = q[i];
                if (!present) begin
                    next_q[i] = 1'b0;
                end else if (global_force_line) begin
                    next_q[i] = init_eff[i];
                end else if (force_any && cfg_async[i]) begin
                    next_q[i] = force_val[i];
                end else if (event_now && force_any) begin
                    next_q[i] = force_val[i];
                end else if (event_now && el_ce[i]) begin
                    next_q[i] = el_d[i];
                end
            end
        end
    endgenerate

    // Storage elements and clock-level history
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ck_q <= 6'h00;
            q <= 6'h00;
        end else begin
            ck_q <= el_ck;
            q <= next_q;
        end
    end
    assign in_reg_upper = q[PPC_EL_IN_U];
    assign in_reg_lower = q[PPC_EL_IN_L];

    // Output and tri muxes; upper half while upper clock is high
    wire o_sel_u = !ddr_out || f_otck1;
    wire t_sel_u = !ddr_tri || f_otck1;
    wire o_a = ctrl[PPC_C_OUT_REG] ? q[PPC_EL_OUT_U] : f_o1;
    wire o_b = ctrl[PPC_C_OUT_REG] ? q[PPC_EL_OUT_L] : f_o2;
    wire t_a = ctrl[PPC_C_TRI_REG] ? q[PPC_EL_TRI_U] : f_t1;
    wire t_b = ctrl[PPC_C_TRI_REG] ? q[PPC_EL_TRI_L] : f_t2;
    wire out_val = o_sel_u ? o_a : o_b;
    wire tri_val = t_sel_u ? t_a : t_b;
    // High tri value releases the pad; input-only cell never drives
    assign pad_out = HAS_OUTPUT && out_val;
    assign pad_oe = HAS_OUTPUT && !tri_val;

    // Read path: status word shows live element state
    wire [31:0] stat_word = {22'h000000, pad_oe, pad_in, in_plain,
        1'b0, q};
    wire rd_ok = s_axi_araddr == PPC_OFS_CTRL ||
        s_axi_araddr == PPC_OFS_ELEM || s_axi_araddr == PPC_OFS_INV ||
        s_axi_araddr == PPC_OFS_STAT;
    wire [31:0] rd_word = (s_axi_araddr == PPC_OFS_CTRL) ?
        {17'h00000, ctrl} : (s_axi_araddr == PPC_OFS_ELEM) ? elem :
        (s_axi_araddr == PPC_OFS_INV) ? {19'h00000, inv} :
        (s_axi_araddr == PPC_OFS_STAT) ? stat_word : 32'h00000000;

    // Read data register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= PPC_RESP_OK;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            rdata_q <= rd_word;
            rresp_q <= rd_ok ? PPC_RESP_OK : PPC_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_LOCK_HOLDS: assert property (
        locked |=> ctrl[14:9] == $past(ctrl[14:9]) && locked)
        else $error("delay field changed after lock");
    AST_BOTH_ZERO: assert property (
        !global_force_line && f_sr && f_rev && cfg_async[PPC_EL_IN_U]
        |=> !q[PPC_EL_IN_U])
        else $error("set and reverse together did not give zero");
    AST_GLOBAL_INIT: assert property (
        global_force_line ##1 1'b1 |-> q[1:0] == $past(init_eff[1:0]))
        else $error("global force did not load start value");
    AST_FF_CAPTURE: assert property (
        !global_force_line && !force_any && !cfg_latch[0] &&
        f_ick1 && !ck_q[0] && f_ice |=> in_reg_upper == $past(sync_d))
        else $error("input flop missed enabled edge");
    AST_FF_HOLD: assert property (
        !global_force_line && !force_any && !cfg_latch[0] &&
        !(f_ick1 && !ck_q[0]) |=> $stable(in_reg_upper))
        else $error("input flop changed without an edge");
    AST_GATE_DEFAULT: assert property (
        !ctrl[PPC_C_IN_GATE] |-> f_ice)
        else $error("unused enable not asserted");
    AST_DDR_MUX: assert property (
        HAS_OUTPUT && ddr_out && ctrl[PPC_C_OUT_REG] && !f_otck1
        |-> pad_out == q[PPC_EL_OUT_L])
        else $error("double-rate mux picked wrong half");
    AST_TRI_RELEASE: assert property (
        HAS_OUTPUT && !ctrl[PPC_C_TRI_REG] && !ddr_tri
        |-> pad_oe == !f_t1)
        else $error("pad driver enable wrong");
    AST_SYNC_TAP: assert property (
        ctrl[PPC_C_COARSE] == 1'b0 && stap == 2'h1 && $stable(ctrl)
        [*3] |-> sync_d == $past(pad_in, 2))
        else $error("storage tap delay wrong");
    AST_BAD_ADDR: assert property (
        s_axi_arvalid && !s_axi_rvalid && !rd_ok
        |=> s_axi_rvalid && s_axi_rresp == PPC_RESP_SLVERR)
        else $error("unmapped read not refused");
    CV_DDR_OUT: cover property (ddr_out && f_otck1 ##1 !f_otck1);
    CV_LATCH: cover property (cfg_latch[0] && f_ick1 && f_ice);
    CV_LOCKED_WRITE: cover property (locked && wr_ctrl);
    CV_DDR_IN: cover property (ctrl[PPC_C_DDR_IN] && !f_ick1 && ck_q[1]);
endmodule : ppc_pin_cell
`default_nettype wire

/* File: core/ppc_pkg.sv */
// Constants, register map and field layout of the programmable pin cell
// Notes on behaviour
// - Pad passes delay to plain output, pair optional
// - Output lines muxed to pad driver, optional pair
// - Three-state lines muxed, optional pair, set high-Z
// - Every fabric input except the global force line has a polarity inverter
// - Input-only variant drops all output logic
// - Coarse 0/2000 ps then eight 250 ps taps
// - Storage inputs pick one of four taps
// - Coarse stage shared by both input routes
// - Delay choices frozen once configuration completes
// - Each element: flop or latch, sync or async
// - Flop captures on enabled edge; latch transparent
// - Unconnected enable behaves as always asserted
// - Set/reset forces chosen level, sync or async
// - Reverse forces opposite; both together give zero
// - Output and tri pairs form double-rate muxes
// - Shared upper/lower out clocks; separate input clocks
// - One enable per pair: out, tri, input
// - One set/reset and one reverse drive six
// - Per-element force level; upper governs double-rate; not applied to the input pair
// - Global force loads start value per element
// - Double-rate start zero on one applies both; not applied to the input pair
// - Double-rate input: lower captures on inverse clock
// - Double-rate output: upper/lower clocks, both forwarded
package ppc_pkg;
    // Register byte offsets
    localparam logic [3:0] PPC_OFS_CTRL = 4'h0;
    localparam logic [3:0] PPC_OFS_ELEM = 4'h4;
    localparam logic [3:0] PPC_OFS_INV = 4'h8;
    localparam logic [3:0] PPC_OFS_STAT = 4'hC;
    // Control register fields
    localparam int PPC_C_LOCK = 0;
    localparam int PPC_C_OUT_REG = 1;
    localparam int PPC_C_TRI_REG = 2;
    localparam int PPC_C_DDR_OUT = 3;
    localparam int PPC_C_DDR_TRI = 4;
    localparam int PPC_C_DDR_IN = 5;
    localparam int PPC_C_IN_GATE = 6;
    localparam int PPC_C_OUT_GATE = 7;
    localparam int PPC_C_TRI_GATE = 8;
    localparam int PPC_C_COARSE = 9;
    localparam int PPC_C_ATAP = 10;
    localparam int PPC_C_STAP = 13;
    localparam int PPC_CTRL_W = 15;
    localparam logic [14:0] PPC_CTRL_RST = 15'h0000;
    // Bits of the control word that the lock freezes
    localparam logic [14:0] PPC_DELAY_MASK = 15'h7E00;
    // Element register fields, one bit per element in each byte
    localparam int PPC_E_LATCH = 0;
    localparam int PPC_E_ASYNC = 8;
    localparam int PPC_E_FONE = 16;
    localparam int PPC_E_INIT = 24;
    localparam logic [31:0] PPC_ELEM_RST = 32'h00000000;
    // Element indices
    localparam int PPC_NEL = 6;
    localparam int PPC_EL_IN_U = 0;
    localparam int PPC_EL_IN_L = 1;
    localparam int PPC_EL_OUT_U = 2;
    localparam int PPC_EL_OUT_L = 3;
    localparam int PPC_EL_TRI_U = 4;
    localparam int PPC_EL_TRI_L = 5;
    // Fabric inputs carrying an inverter, in inversion-mask order
    localparam int PPC_NINV = 13;
    localparam logic [12:0] PPC_INV_RST = 13'h0000;
    // Delay line timing
    localparam int PPC_CLK_PS = 8000;
    localparam int PPC_COARSE_PS = 2000;
    localparam int PPC_TAP_PS = 250;
    localparam int PPC_NTAP = 8;
    localparam int PPC_SYNC_STEP = 2;
    localparam int PPC_COARSE_CYC = (PPC_COARSE_PS + PPC_CLK_PS - 1)
        / PPC_CLK_PS;
    localparam int PPC_TAP_CYC = (PPC_TAP_PS + PPC_CLK_PS - 1) / PPC_CLK_PS;
    // AXI responses
    localparam logic [1:0] PPC_RESP_OK = 2'h0;
    localparam logic [1:0] PPC_RESP_SLVERR = 2'h2;
endpackage : ppc_pkg

/* File: testbench/ppc_pad_model.sv */
// Pad-side partner: resolves the pad wire from both drivers
`timescale 1ns/1ps
`default_nettype none
module ppc_pad_model (
    // Cell side
    input wire logic pad_out,
    input wire logic pad_oe,
    // Far-side board driver
    input wire logic ext_val,
    input wire logic ext_en,
    // Resolved wire level
    output logic pad_in
);
    // No pull on the wire, so a floating pad shows the inverse level
    always @(pad_out, pad_oe, ext_val, ext_en) begin
        if (pad_oe === 1'b1)
            pad_in = pad_out;
        else if (ext_en)
            pad_in = ext_val;
        else
            pad_in = ~pad_in;
    end
endmodule : ppc_pad_model
`default_nettype wire

/* File: testbench/ppc_pin_cell_bench.sv */
// Self-checking bench for the programmable pin cell
`timescale 1ns/1ps
`default_nettype none
module ppc_pin_cell_bench
    import ppc_pkg::*;
;
    logic aclk, aresetn, gf, ext_val, pad_in, pad_out, pad_oe;
    logic in_plain, iru, irl;
    logic [12:0] fab;
    logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
    logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    int n_fail, n_tests;

    // Fabric lines packed in inversion-mask order
    ppc_pin_cell #(.HAS_OUTPUT(1'b1)) ppc_pin_cell_i (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .pad_in, .pad_out, .pad_oe,
        .out_data_upper(fab[0]), .out_data_lower(fab[1]),
        .tri_ctrl_upper(fab[2]), .tri_ctrl_lower(fab[3]),
        .out_tri_upper_clock(fab[4]), .out_tri_lower_clock(fab[5]),
        .in_upper_clock(fab[6]), .in_lower_clock(fab[7]),
        .out_pair_gate(fab[8]), .tristate_pair_gate(fab[9]),
        .in_pair_gate(fab[10]), .set_reset_line(fab[11]),
        .opposite_force_line(fab[12]), .global_force_line(gf),
        .in_plain, .in_reg_upper(iru), .in_reg_lower(irl)
    );
    ppc_pad_model ppc_pad_model_i (
        .pad_out, .pad_oe, .ext_val, .ext_en(1'b1), .pad_in
    );

    // 125 MHz clock
    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    // Write; bready stays high so each response is taken at once
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do cyc(1); while ((s_axi_awready & s_axi_wready) !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do cyc(1); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask : wr

    task automatic rd(input logic [3:0] a);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do cyc(1); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do cyc(1); while (s_axi_rvalid !== 1'b1);
        rdv = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd

    // One element clock pulse, then let the capture land
    task automatic pls(input int b);
        fab[b] <= 1'b1;
        cyc(1);
        fab[b] <= 1'b0;
        cyc(2);
    endtask : pls

    task automatic gfp();
        gf <= 1'b1;
        cyc(1);
        gf <= 1'b0;
        cyc(1);
    endtask : gfp

    // Cycles from a pad step to a rise on the chosen output
    task automatic lat(input logic [31:0] c, input bit s, output int n);
        wr(PPC_OFS_CTRL, c);
        ext_val <= 1'b0;
        cyc(12);
        ext_val <= 1'b1;
        n = 0;
        do begin
            cyc(1);
            n++;
        end while ((s ? iru : in_plain) !== 1'b1 && n < 30);
    endtask : lat

    task automatic t_regs();
        rd(PPC_OFS_CTRL);
        chk("ctrl reset", rdv, 32'h0);
        chk("ctrl read resp", resp, PPC_RESP_OK);
        rd(4'h2);
        chk("unmapped read resp", resp, PPC_RESP_SLVERR);
        rd(PPC_OFS_ELEM);
        chk("elem reset", rdv, 32'h0);
        wr(4'h2, 32'hFFFFFFFF);
        chk("unmapped resp", resp, PPC_RESP_SLVERR);
        wr(PPC_OFS_STAT, 32'hFFFFFFFF);
        chk("status write resp", resp, PPC_RESP_SLVERR);
        wr(PPC_OFS_INV, 32'hFFFFFFFF);
        rd(PPC_OFS_INV);
        chk("inv width", rdv, 32'h1FFF);
        wr(PPC_OFS_INV, 32'h0);
    endtask : t_regs

    task automatic t_direct();
        fab[0] <= 1'b1;
        fab[2] <= 1'b0;
        cyc(1);
        chk("direct out", pad_out, 1'b1);
        chk("direct oe", pad_oe, 1'b1);
        fab[2] <= 1'b1;
        cyc(1);
        chk("released oe", pad_oe, 1'b0);
        wr(PPC_OFS_INV, 32'h5);
        chk("inverted out", pad_out, 1'b0);
        chk("inverted oe", pad_oe, 1'b1);
        wr(PPC_OFS_INV, 32'h0);
    endtask : t_direct

    // Differences between settings cancel the fixed pipeline latency
    task automatic t_delay();
        int a, b;
        fab[6] <= 1'b1;
        wr(PPC_OFS_ELEM, 32'h1);
        lat(32'h0, 1'b0, a);
        lat(32'h0E00, 1'b0, b);
        chk("coarse+tap3", 32'(b - a), 32'd4);
        lat(32'h1C00, 1'b0, b);
        chk("tap7", 32'(b - a), 32'd7);
        lat(32'h0, 1'b1, a);
        lat(32'h4000, 1'b1, b);
        chk("sync tap2", 32'(b - a), 32'd4);
        lat(32'h4200, 1'b1, b);
        chk("sync coarse", 32'(b - a), 32'd5);
        fab[6] <= 1'b0;
    endtask : t_delay

    task automatic t_store();
        wr(PPC_OFS_ELEM, 32'h0);
        wr(PPC_OFS_CTRL, 32'h40);
        gfp();
        fab[10] <= 1'b0;
        ext_val <= 1'b1;
        cyc(10);
        pls(6);
        chk("gated flop", iru, 1'b0);
        fab[10] <= 1'b1;
        pls(6);
        chk("enabled flop", iru, 1'b1);
        fab[10] <= 1'b0;
        wr(PPC_OFS_CTRL, 32'h0);
        ext_val <= 1'b0;
        cyc(10);
        pls(6);
        chk("open enable", iru, 1'b0);
    endtask : t_store

    task automatic t_force();
        wr(PPC_OFS_ELEM, 32'h00010000);
        wr(PPC_OFS_CTRL, 32'h40);
        fab[11] <= 1'b1;
        pls(6);
        chk("sync set", iru, 1'b1);
        fab[11] <= 1'b0;
        fab[12] <= 1'b1;
        pls(6);
        chk("reverse of one", iru, 1'b0);
        wr(PPC_OFS_ELEM, 32'h0);
        pls(6);
        chk("reverse of zero", iru, 1'b1);
        fab[11] <= 1'b1;
        pls(6);
        chk("both lines", iru, 1'b0);
        fab[12] <= 1'b0;
        wr(PPC_OFS_ELEM, 32'h003F3F00);
        rd(PPC_OFS_STAT);
        chk("async all six", rdv & 32'h3F, 32'h3F);
        fab[11] <= 1'b0;
        wr(PPC_OFS_ELEM, 32'h15000000);
        gfp();
        rd(PPC_OFS_STAT);
        chk("start values", rdv & 32'h3F, 32'h15);
        wr(PPC_OFS_CTRL, 32'h8);
        wr(PPC_OFS_ELEM, 32'h04000000);
        gfp();
        rd(PPC_OFS_STAT);
        chk("ddr start zero", rdv & 32'h3F, 32'h0);
    endtask : t_force

    task automatic t_ddr_out();
        wr(PPC_OFS_CTRL, 32'h0A);
        fab[0] <= 1'b1;
        fab[1] <= 1'b0;
        fab[2] <= 1'b0;
        fab[5] <= 1'b1;
        cyc(1);
        fab[5] <= 1'b0;
        fab[4] <= 1'b1;
        cyc(1);
        fab[0] <= 1'b0;
        fab[1] <= 1'b1;
        cyc(1);
        chk("ddr high phase", pad_out, 1'b1);
        chk("ddr drive", pad_oe, 1'b1);
        fab[4] <= 1'b0;
        cyc(1);
        chk("ddr low phase", pad_out, 1'b0);
        fab[2] <= 1'b1;
    endtask : t_ddr_out

    task automatic t_ddr_in();
        wr(PPC_OFS_CTRL, 32'h20);
        wr(PPC_OFS_ELEM, 32'h0);
        gfp();
        ext_val <= 1'b0;
        cyc(10);
        fab[6] <= 1'b1;
        cyc(3);
        ext_val <= 1'b1;
        cyc(10);
        fab[6] <= 1'b0;
        cyc(3);
        chk("ddr in upper", iru, 1'b0);
        chk("ddr in lower", irl, 1'b1);
    endtask : t_ddr_in

    // Lock is sticky, so this runs last
    task automatic t_lock();
        wr(PPC_OFS_CTRL, 32'h0201);
        wr(PPC_OFS_CTRL, 32'h1C01);
        rd(PPC_OFS_CTRL);
        chk("frozen delay", rdv & 32'h7E01, 32'h0201);
    endtask : t_lock

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : end_sim

    // Main sequence
    initial begin
        aresetn = 1'b0;
        gf = 1'b0;
        ext_val = 1'b0;
        fab = 13'h0004;
        s_axi_awaddr = 4'h0;
        s_axi_araddr = 4'h0;
        s_axi_wstrb = 4'hF;
        s_axi_wdata = 32'h0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_bready = 1'b1;
        s_axi_rready = 1'b1;
        cyc(3);
        aresetn <= 1'b1;
        cyc(1);
        t_regs();
        t_direct();
        t_delay();
        t_store();
        t_force();
        t_ddr_out();
        t_ddr_in();
        t_lock();
        end_sim();
    end

    // Whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge aclk);
        n_fail++;
        end_sim();
    end
endmodule : ppc_pin_cell_bench
`default_nettype wire
